// ==== crg_params.svh ====
// Constants of the clock and reset generator: offsets, fields, reset values, timing
// How it works
// RULE1 - Run mode runs everything; periodic interrupt and watchdog need nonzero rate fields.
// RULE2 - Wait mode gates system and core clocks per clock select enable bits.
// RULE3 - Stop kind select bit: zero gives full stop, one gives pseudo-stop.
// RULE4 - Full stop disables the oscillator, halting all system and core clocks.
// RULE5 - Full stop freezes watchdog and periodic interrupt counters.
// RULE6 - Pseudo-stop keeps oscillator running while most clocks stop.
// RULE7 - Pseudo-stop counters run only when their run-in-stop bits are set.
// RULE8 - Self-clock entry needs monitor enable, self-clock enable and reported clock loss.
// RULE9 - Entering self-clock mode starts the clock quality check at once.
// RULE10 - Self-clock mode lasts until quality check passes frequency and amplitude.
// RULE11 - PLL entering or leaving lock raises an interrupt request.
// RULE12 - Watchdog service outside the permitted window is not a valid clear.
// RULE13 - System reset from power-on, low voltage, watchdog, clock loss, reset pin.
// RULE14 - Reset pin is active low; driven low from outside it initialises the device.
// RULE15 - Internal system reset drives the reset pin low, open drain.
// RULE16 - Registers decode as base plus offset, twelve registers at offsets 0x0 to 0xB.
// RULE17 - Test flag, force/bypass and test control registers have no functional effect.
// RULE18 - Self-clock mode derives all clocks from the PLL at minimum frequency.
// RULE19 - Every register is eight bits wide, single byte reads and writes.
`ifndef CRG_PARAMS_SVH
`define CRG_PARAMS_SVH
`define CRG_IDX_SYNTH      4'h0
`define CRG_IDX_REFDIV     4'h1
`define CRG_IDX_TEST_FLAG  4'h2
`define CRG_IDX_FLAGS      4'h3
`define CRG_IDX_INT_EN     4'h4
`define CRG_IDX_CLK_SEL    4'h5
`define CRG_IDX_PLL_CTL    4'h6
`define CRG_IDX_PI_RATE    4'h7
`define CRG_IDX_WD_CTL     4'h8
`define CRG_IDX_FORCE_BYP  4'h9
`define CRG_IDX_TEST_CTL   4'ha
`define CRG_IDX_WD_ARM     4'hb
`define CRG_FLG_PI         7
`define CRG_FLG_POR        6
`define CRG_FLG_LVR        5
`define CRG_FLG_LOCK_CHG   4
`define CRG_FLG_SC_CHG     1
`define CRG_CS_PLL_SEL     7
`define CRG_CS_STOP_KIND   6
`define CRG_CS_SYS_WAIT    5
`define CRG_CS_PLL_WAIT    3
`define CRG_CS_CORE_WAIT   2
`define CRG_CS_PI_WAIT     1
`define CRG_CS_WD_WAIT     0
`define CRG_PC_CLK_MON     7
`define CRG_PC_PLL_ON      6
`define CRG_PC_PI_STOP     2
`define CRG_PC_WD_STOP     1
`define CRG_PC_SELF_CLK    0
`define CRG_WD_WINDOW      7
`define CRG_MASK_SYNTH     8'h3f
`define CRG_MASK_REFDIV    8'h0f
`define CRG_MASK_INT_EN    8'h92
`define CRG_MASK_PLL_CTL   8'hf7
`define CRG_MASK_PI_RATE   8'h7f
`define CRG_MASK_WD_CTL    8'hc7
`define CRG_RST_PLL_CTL    8'hf1
`define CRG_RST_OTHER      8'h00
`define CRG_WD_KEY_ARM     8'h55
`define CRG_WD_KEY_FIRE    8'haa
`define CRG_RESP_OKAY      2'h0
`define CRG_RESP_SLVERR    2'h2
`define CRG_ASYNC_RST      7'h40
`define CRG_CLK_PERIOD_NS  20
`define CRG_RST_HOLD_NS    640
`define CRG_RST_HOLD_CYC   ((`CRG_RST_HOLD_NS + `CRG_CLK_PERIOD_NS - 1) / `CRG_CLK_PERIOD_NS)
`endif

// ==== crg_pkg.sv ====
// Types of the clock and reset generator
package crg_pkg;
	typedef enum logic [1:0] {
		CRG_RUN,
		CRG_WAIT,
		CRG_FULL_STOP,
		CRG_PSEUDO_STOP
	} crg_mode_t;

	// Inputs from pins and analog cells, asynchronous to aclk
	typedef struct packed {
		logic ext_reset_n;
		logic power_on;
		logic low_voltage;
		logic osc_loss;
		logic quality_ok;
		logic pll_lock;
		logic pll_track;
	} crg_async_t;

	typedef struct packed {
		logic sys_clk_en;
		logic core_clk_en;
		logic osc_enable;
		logic pll_enable;
		logic pll_select;
		logic pll_min_freq;
		logic self_clock_status;
		logic quality_check;
	} crg_clk_ctl_t;
endpackage

// ==== crg_top.sv ====
// Clock and reset generator: modes, self-clock, watchdog, periodic interrupt, resets, AXI4-Lite registers
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "crg_params.svh"
module crg_top #(
	parameter int AW            = 8,
	parameter int WD_BASE_SHIFT = 14,
	parameter int PI_BASE_SHIFT = 10
) (
	// Clock, reset, enable
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  clk_en,
	// AXI4-Lite slave
	input  wire logic [AW-1:0]         s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AW-1:0]         s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Pins and analog cells
	input  wire crg_pkg::crg_async_t   async_in,
	output logic                       reset_pin_out,
	output logic                       reset_pin_oe,
	// Core power requests
	input  wire logic                  wait_req,
	input  wire logic                  stop_req,
	input  wire logic                  wake_req,
	// Clock control and results
	output crg_pkg::crg_clk_ctl_t      clk_ctl,
	output logic [5:0]                 pll_mult,
	output logic [3:0]                 pll_refdiv,
	output logic                       sys_reset_n,
	output logic                       irq
);
	import crg_pkg::*;

	localparam int WD_W = WD_BASE_SHIFT + 15;
	localparam int PI_W = PI_BASE_SHIFT + 12;
	localparam logic [7:0] RST_HOLD = 8'(`CRG_RST_HOLD_CYC);

	generate
		if (AW < 7 || WD_BASE_SHIFT < 2 || PI_BASE_SHIFT < 1) begin : g_bad
			$error("crg_top: parameter out of range");
		end
	endgenerate

	crg_async_t   sync1_ff;
	crg_async_t   sync2_ff;
	crg_mode_t    mode_ff;
	crg_mode_t    nxt_mode;
	crg_clk_ctl_t clk_ctl_ff;
	crg_clk_ctl_t nxt_clk_ctl;
	logic         soft_rst;
	logic         sys_reset_n_ff;
	logic         pin_oe_ff;
	logic         pin_out_ff;
	logic [7:0]   rst_cnt_ff;
	logic [7:0]   nxt_rst_cnt;
	logic         int_rst;
	logic         irq_ff;
	logic         wake;

	// Register storage
	logic [7:0]   synth_multiplier_ff;
	logic [7:0]   reference_divider_ff;
	logic [7:0]   interrupt_enable_ff;
	logic [7:0]   clock_select_reg_ff;
	logic [7:0]   pll_control_ff;
	logic [7:0]   periodic_rate_reg_ff;
	logic [7:0]   watchdog_control_reg_ff;

	// Flags and status
	logic         pi_flag_ff;
	logic         por_flag_ff;
	logic         lvr_flag_ff;
	logic         lock_chg_ff;
	logic         lock_ff;
	logic         track_ff;
	logic         sc_chg_ff;
	logic         self_clock_ff;
	logic         nxt_pi_flag;
	logic         nxt_por_flag;
	logic         nxt_lvr_flag;
	logic         nxt_lock_chg;
	logic         nxt_lock;
	logic         nxt_track;
	logic         nxt_sc_chg;
	logic         nxt_self_clock;
	logic         loc_reset;

	// Bus state
	logic         aw_full_ff;
	logic         w_full_ff;
	logic [3:0]   wr_idx_ff;
	logic         wr_map_ff;
	logic [7:0]   wr_data_ff;
	logic         wr_lane_ff;
	logic         bvalid_ff;
	logic [1:0]   bresp_ff;
	logic         awready_ff;
	logic         wready_ff;
	logic         arready_ff;
	logic         rvalid_ff;
	logic [1:0]   rresp_ff;
	logic [7:0]   rdata_ff;
	logic         wr_fire;
	logic         wr_ok;
	logic         aw_take;
	logic         w_take;
	logic         ar_take;
	logic         nxt_aw_full;
	logic         nxt_w_full;
	logic         nxt_bvalid;
	logic         nxt_rvalid;
	logic [3:0]   rd_idx;
	logic         rd_map;
	logic [7:0]   rd_val;
	logic [7:0]   flag_clr;

	// Watchdog and periodic interrupt
	logic [WD_W-1:0] wd_cnt_ff;
	logic [WD_W-1:0] wd_period;
	logic            wd_armed_ff;
	logic            wd_on;
	logic            wd_run;
	logic            wd_open;
	logic            wd_timeout;
	logic            wd_restart;
	logic            wd_fault;
	logic [PI_W-1:0] pi_cnt_ff;
	logic [PI_W-1:0] pi_period;
	logic            pi_on;
	logic            pi_run;
	logic            pi_tick;

	// Two-stage synchroniser for everything from outside aclk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= crg_async_t'(`CRG_ASYNC_RST);
			sync2_ff <= crg_async_t'(`CRG_ASYNC_RST);
		end else if (clk_en) begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
		end
	end

	// Reset collection and pin drive
	assign loc_reset = pll_control_ff[`CRG_PC_CLK_MON] && !pll_control_ff[`CRG_PC_SELF_CLK]
		&& sync2_ff.osc_loss && !self_clock_ff;
	assign int_rst = sync2_ff.power_on || sync2_ff.low_voltage || wd_timeout || wd_fault || loc_reset; // RULE13

	always_comb begin
		nxt_rst_cnt = rst_cnt_ff;
		if (int_rst) begin
			nxt_rst_cnt = RST_HOLD;
		end else if (rst_cnt_ff != 8'h00) begin
			nxt_rst_cnt = rst_cnt_ff - 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_cnt_ff     <= RST_HOLD;
			pin_oe_ff      <= 1'b1;
			pin_out_ff     <= 1'b0;
			sys_reset_n_ff <= 1'b0;
		end else if (clk_en) begin
			rst_cnt_ff     <= nxt_rst_cnt;
			pin_oe_ff      <= nxt_rst_cnt != 8'h00; // RULE15
			pin_out_ff     <= 1'b0;
			// Pin reads back its own drive, which keeps reset held past the end of the stretch for the synchroniser delay
			sys_reset_n_ff <= (nxt_rst_cnt == 8'h00) && sync2_ff.ext_reset_n; // RULE14
		end
	end

	// Power-on and low-voltage flags survive the soft reset
	assign soft_rst = !aresetn || !sys_reset_n_ff; // RULE14

	// Power mode machine
	assign wake = wake_req || irq_ff;

	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			CRG_RUN: begin
				if (stop_req) begin
					nxt_mode = clock_select_reg_ff[`CRG_CS_STOP_KIND] ? CRG_PSEUDO_STOP : CRG_FULL_STOP; // RULE3
				end else if (wait_req) begin
					nxt_mode = CRG_WAIT;
				end
			end
			CRG_WAIT: begin
				if (wake) begin
					nxt_mode = CRG_RUN;
				end
			end
			CRG_FULL_STOP: begin
				if (wake) begin
					nxt_mode = CRG_RUN;
				end
			end
			CRG_PSEUDO_STOP: begin
				if (wake) begin
					nxt_mode = CRG_RUN;
				end
			end
			default: nxt_mode = CRG_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			mode_ff <= CRG_RUN;
		end else if (clk_en) begin
			mode_ff <= nxt_mode;
		end
	end

	always_comb begin
		nxt_clk_ctl.sys_clk_en  = (nxt_mode == CRG_RUN)
			|| (nxt_mode == CRG_WAIT && !clock_select_reg_ff[`CRG_CS_SYS_WAIT]); // RULE2
		nxt_clk_ctl.core_clk_en = (nxt_mode == CRG_RUN)
			|| (nxt_mode == CRG_WAIT && !clock_select_reg_ff[`CRG_CS_CORE_WAIT]); // RULE2
		nxt_clk_ctl.osc_enable  = nxt_mode != CRG_FULL_STOP; // RULE4 RULE6
		nxt_clk_ctl.pll_enable  = nxt_self_clock || (pll_control_ff[`CRG_PC_PLL_ON]
			&& (nxt_mode == CRG_RUN || (nxt_mode == CRG_WAIT && !clock_select_reg_ff[`CRG_CS_PLL_WAIT])));
		nxt_clk_ctl.pll_select  = nxt_self_clock || clock_select_reg_ff[`CRG_CS_PLL_SEL]; // RULE18
		nxt_clk_ctl.pll_min_freq      = nxt_self_clock; // RULE18
		nxt_clk_ctl.self_clock_status = nxt_self_clock;
		nxt_clk_ctl.quality_check     = nxt_self_clock; // RULE9
	end

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			clk_ctl_ff <= '0;
		end else if (clk_en) begin
			clk_ctl_ff <= nxt_clk_ctl;
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	assign aw_take     = s_axi_awvalid && awready_ff;
	assign w_take      = s_axi_wvalid && wready_ff;
	assign wr_fire     = aw_full_ff && w_full_ff && !bvalid_ff;
	assign wr_ok       = wr_fire && wr_map_ff && wr_lane_ff; // RULE19
	assign nxt_aw_full = aw_take || (aw_full_ff && !wr_fire);
	assign nxt_w_full  = w_take || (w_full_ff && !wr_fire);
	assign nxt_bvalid  = wr_fire || (bvalid_ff && !s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `CRG_RESP_OKAY;
			wr_idx_ff  <= 4'h0;
			wr_map_ff  <= 1'b0;
			wr_data_ff <= 8'h00;
			wr_lane_ff <= 1'b0;
		end else if (clk_en) begin
			aw_full_ff <= nxt_aw_full;
			w_full_ff  <= nxt_w_full;
			awready_ff <= !nxt_aw_full && !nxt_bvalid;
			wready_ff  <= !nxt_w_full && !nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			if (aw_take) begin
				wr_idx_ff <= s_axi_awaddr[5:2];
				wr_map_ff <= (s_axi_awaddr[AW-1:6] == '0) && (s_axi_awaddr[5:2] <= `CRG_IDX_WD_ARM); // RULE16
			end
			if (w_take) begin
				wr_data_ff <= s_axi_wdata[7:0];
				wr_lane_ff <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				bresp_ff <= wr_map_ff ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
			end
		end
	end

	// AXI4-Lite read path
	assign ar_take    = s_axi_arvalid && arready_ff;
	assign nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);
	assign rd_idx     = s_axi_araddr[5:2];
	assign rd_map     = (s_axi_araddr[AW-1:6] == '0) && (rd_idx <= `CRG_IDX_WD_ARM); // RULE16

	// Test registers and the arm register read back as zero
	always_comb begin
		rd_val = 8'h00; // RULE17
		if (!rd_map) begin
			rd_val = 8'h00;
		end else if (rd_idx == `CRG_IDX_SYNTH) begin
			rd_val = synth_multiplier_ff;
		end else if (rd_idx == `CRG_IDX_REFDIV) begin
			rd_val = reference_divider_ff;
		end else if (rd_idx == `CRG_IDX_FLAGS) begin
			rd_val = {pi_flag_ff, por_flag_ff, lvr_flag_ff, lock_chg_ff, lock_ff, track_ff, sc_chg_ff, self_clock_ff};
		end else if (rd_idx == `CRG_IDX_INT_EN) begin
			rd_val = interrupt_enable_ff;
		end else if (rd_idx == `CRG_IDX_CLK_SEL) begin
			rd_val = clock_select_reg_ff;
		end else if (rd_idx == `CRG_IDX_PLL_CTL) begin
			rd_val = pll_control_ff;
		end else if (rd_idx == `CRG_IDX_PI_RATE) begin
			rd_val = periodic_rate_reg_ff;
		end else if (rd_idx == `CRG_IDX_WD_CTL) begin
			rd_val = watchdog_control_reg_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= `CRG_RESP_OKAY;
			rdata_ff   <= 8'h00;
		end else if (clk_en) begin
			arready_ff <= !nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= rd_val;
				rresp_ff <= rd_map ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			synth_multiplier_ff     <= `CRG_RST_OTHER;
			reference_divider_ff    <= `CRG_RST_OTHER;
			interrupt_enable_ff     <= `CRG_RST_OTHER;
			clock_select_reg_ff     <= `CRG_RST_OTHER;
			pll_control_ff          <= `CRG_RST_PLL_CTL;
			periodic_rate_reg_ff    <= `CRG_RST_OTHER;
			watchdog_control_reg_ff <= `CRG_RST_OTHER;
		end else if (clk_en && wr_ok) begin
			// Divider ratios are locked while the PLL select bit of clock select is set
			if (wr_idx_ff == `CRG_IDX_SYNTH && !clock_select_reg_ff[`CRG_CS_PLL_SEL]) begin
				synth_multiplier_ff <= wr_data_ff & `CRG_MASK_SYNTH;
			end else if (wr_idx_ff == `CRG_IDX_REFDIV && !clock_select_reg_ff[`CRG_CS_PLL_SEL]) begin
				reference_divider_ff <= wr_data_ff & `CRG_MASK_REFDIV;
			end else if (wr_idx_ff == `CRG_IDX_INT_EN) begin
				interrupt_enable_ff <= wr_data_ff & `CRG_MASK_INT_EN;
			end else if (wr_idx_ff == `CRG_IDX_CLK_SEL) begin
				clock_select_reg_ff <= wr_data_ff;
			end else if (wr_idx_ff == `CRG_IDX_PLL_CTL) begin
				pll_control_ff <= wr_data_ff & `CRG_MASK_PLL_CTL;
			end else if (wr_idx_ff == `CRG_IDX_PI_RATE) begin
				periodic_rate_reg_ff <= wr_data_ff & `CRG_MASK_PI_RATE;
			end else if (wr_idx_ff == `CRG_IDX_WD_CTL) begin
				watchdog_control_reg_ff <= wr_data_ff & `CRG_MASK_WD_CTL;
			end
		end
	end

	// Watchdog
	assign wd_on     = watchdog_control_reg_ff[2:0] != 3'h0; // RULE1
	assign wd_run    = wd_on && ((mode_ff == CRG_RUN) // RULE5
		|| (mode_ff == CRG_WAIT && !clock_select_reg_ff[`CRG_CS_WD_WAIT])
		|| (mode_ff == CRG_PSEUDO_STOP && pll_control_ff[`CRG_PC_WD_STOP])); // RULE7
	assign wd_period = {{(WD_W-1){1'b0}}, 1'b1} << (WD_BASE_SHIFT + 2 * int'(watchdog_control_reg_ff[2:0]));
	// Last quarter of the period is the service window
	assign wd_open   = wd_cnt_ff >= (wd_period - (wd_period >> 2));
	assign wd_timeout = wd_run && (wd_cnt_ff == wd_period - {{(WD_W-1){1'b0}}, 1'b1});
	assign wd_restart = wr_ok && wr_idx_ff == `CRG_IDX_WD_ARM && wd_on && wd_armed_ff
		&& wr_data_ff == `CRG_WD_KEY_FIRE;
	assign wd_fault  = wr_ok && wr_idx_ff == `CRG_IDX_WD_ARM && wd_on && !wd_restart
		&& !(wr_data_ff == `CRG_WD_KEY_ARM && (!watchdog_control_reg_ff[`CRG_WD_WINDOW] || wd_open)); // RULE12

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			wd_cnt_ff   <= '0;
			wd_armed_ff <= 1'b0;
		end else if (clk_en) begin
			if (wd_restart || !wd_on) begin
				wd_cnt_ff <= '0;
			end else if (wd_run) begin
				wd_cnt_ff <= wd_cnt_ff + {{(WD_W-1){1'b0}}, 1'b1};
			end
			if (wr_ok && wr_idx_ff == `CRG_IDX_WD_ARM) begin
				wd_armed_ff <= !wd_restart && !wd_fault; // RULE12
			end
		end
	end

	// Periodic interrupt
	assign pi_on     = periodic_rate_reg_ff[6:0] != 7'h00; // RULE1
	assign pi_run    = pi_on && ((mode_ff == CRG_RUN) // RULE5
		|| (mode_ff == CRG_WAIT && !clock_select_reg_ff[`CRG_CS_PI_WAIT])
		|| (mode_ff == CRG_PSEUDO_STOP && pll_control_ff[`CRG_PC_PI_STOP])); // RULE7
	assign pi_period = (PI_W'(periodic_rate_reg_ff[3:0]) + {{(PI_W-1){1'b0}}, 1'b1})
		<< (PI_BASE_SHIFT + int'(periodic_rate_reg_ff[6:4]));
	assign pi_tick   = pi_run && (pi_cnt_ff == pi_period - {{(PI_W-1){1'b0}}, 1'b1});

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			pi_cnt_ff <= '0;
		end else if (clk_en) begin
			if (pi_tick || !pi_on) begin
				pi_cnt_ff <= '0;
			end else if (pi_run) begin
				pi_cnt_ff <= pi_cnt_ff + {{(PI_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Flags: write one to clear, a set in the same cycle wins
	assign flag_clr = (wr_ok && wr_idx_ff == `CRG_IDX_FLAGS) ? wr_data_ff : 8'h00;

	always_comb begin
		nxt_self_clock = self_clock_ff;
		if (!self_clock_ff && pll_control_ff[`CRG_PC_CLK_MON] && pll_control_ff[`CRG_PC_SELF_CLK]
			&& sync2_ff.osc_loss) begin
			nxt_self_clock = 1'b1; // RULE8
		end else if (self_clock_ff && sync2_ff.quality_ok) begin
			nxt_self_clock = 1'b0; // RULE10
		end
		// Ratio writes restart lock detection
		nxt_lock  = sync2_ff.pll_lock && !nxt_self_clock
			&& !(wr_ok && (wr_idx_ff == `CRG_IDX_SYNTH || wr_idx_ff == `CRG_IDX_REFDIV));
		nxt_track = sync2_ff.pll_track && nxt_lock;
		nxt_pi_flag  = (pi_flag_ff && !flag_clr[`CRG_FLG_PI]) || pi_tick;
		nxt_por_flag = (por_flag_ff && !flag_clr[`CRG_FLG_POR]) || sync2_ff.power_on;
		nxt_lvr_flag = (lvr_flag_ff && !flag_clr[`CRG_FLG_LVR]) || sync2_ff.low_voltage;
		nxt_lock_chg = (lock_chg_ff && !flag_clr[`CRG_FLG_LOCK_CHG]) || (nxt_lock != lock_ff); // RULE11
		nxt_sc_chg   = (sc_chg_ff && !flag_clr[`CRG_FLG_SC_CHG]) || (nxt_self_clock != self_clock_ff);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_flag_ff <= 1'b1;
			lvr_flag_ff <= 1'b0;
		end else if (clk_en) begin
			por_flag_ff <= nxt_por_flag;
			lvr_flag_ff <= nxt_lvr_flag;
		end
	end

	always_ff @(posedge aclk) begin
		if (soft_rst) begin
			pi_flag_ff    <= 1'b0;
			lock_chg_ff   <= 1'b0;
			lock_ff       <= 1'b0;
			track_ff      <= 1'b0;
			sc_chg_ff     <= 1'b0;
			self_clock_ff <= 1'b0;
			irq_ff        <= 1'b0;
		end else if (clk_en) begin
			pi_flag_ff    <= nxt_pi_flag;
			lock_chg_ff   <= nxt_lock_chg;
			lock_ff       <= nxt_lock;
			track_ff      <= nxt_track;
			sc_chg_ff     <= nxt_sc_chg;
			self_clock_ff <= nxt_self_clock;
			irq_ff        <= (nxt_pi_flag && interrupt_enable_ff[`CRG_FLG_PI])
				|| (nxt_lock_chg && interrupt_enable_ff[`CRG_FLG_LOCK_CHG]) // RULE11
				|| (nxt_sc_chg && interrupt_enable_ff[`CRG_FLG_SC_CHG]);
		end
	end

	// Outputs
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = {24'h00_0000, rdata_ff};
	assign reset_pin_out = pin_out_ff;
	assign reset_pin_oe  = pin_oe_ff;
	assign clk_ctl       = clk_ctl_ff;
	assign pll_mult      = synth_multiplier_ff[5:0];
	assign pll_refdiv    = reference_divider_ff[3:0];
	assign sys_reset_n   = sys_reset_n_ff;
	assign irq           = irq_ff;
endmodule

// ==== crg_assertions.sv ====
// Bus, reset-pin and self-clock checker bound to the generator top
`timescale 1ns/1ps
module crg_checker #(
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  clk_en,
	// Register bus
	input wire logic                  s_axi_awready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [AW-1:0]         s_axi_araddr,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	// Pins and clock control
	input wire crg_pkg::crg_async_t   async_in,
	input wire logic                  reset_pin_out,
	input wire logic                  reset_pin_oe,
	input wire crg_pkg::crg_clk_ctl_t clk_ctl,
	input wire logic                  sys_reset_n
);
	import crg_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready && clk_en;
	endsequence
	sequence s_sc_entry;
		$rose(clk_ctl.self_clock_status);
	endsequence
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken with response pending");
	a_bad_index: assert property (s_rd_take ##0 s_axi_araddr[AW-1:2] > 11 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
		else $error("unmapped read not refused");
	a_good_index: assert property (s_rd_take ##0 s_axi_araddr[AW-1:2] <= 11 |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 0)
		else $error("mapped read wrong");
	a_pin_drive: assert property (reset_pin_oe |-> !sys_reset_n && !reset_pin_out)
		else $error("pin driven outside reset");
	a_ext_pin: assert property ($fell(async_in.ext_reset_n) |-> ##[1:5] !sys_reset_n)
		else $error("pin low ignored");
	a_sc_check: assert property (s_sc_entry |-> clk_ctl.quality_check && clk_ctl.pll_min_freq && clk_ctl.pll_select)
		else $error("self-clock entry incomplete");
	a_sc_stay: assert property ((!async_in.quality_ok)[*4] ##0 clk_ctl.self_clock_status |=> clk_ctl.self_clock_status || !sys_reset_n)
		else $error("self-clock left early");
endmodule
bind crg_top crg_checker #(.AW(AW)) u_chk (.*);

// ==== crg_partner.sv ====
// Far side: reset pin with pull-up, oscillator monitor and PLL status
`timescale 1ns/1ps
module crg_partner (
	// Device side
	input wire logic            reset_pin_oe,
	output crg_pkg::crg_async_t async_in,
	// Bench controls
	input wire logic            pin_low,
	input wire logic [5:0]      ana
);
	import crg_pkg::*;
	// Pull-up: either party pulling makes the pin low
	assign async_in = {!(reset_pin_oe || pin_low), ana};
endmodule

// ==== clock_reset_generator_tb_top.sv ====
// Self-checking bench of the clock and reset generator
`timescale 1ns/1ps
module clock_reset_generator_tb_top;
	import crg_pkg::*;
	localparam int AW = 8;
	logic aclk = 0, aresetn = 0, clk_en = 1, wait_req = 0, stop_req = 0, wake_req = 0, pin_low = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, v;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, pll_refdiv;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_out, reset_pin_oe;
	logic sys_reset_n, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [5:0] pll_mult, ana = 0;
	crg_async_t async_in;
	crg_clk_ctl_t clk_ctl;
	logic [7:0] mdl [13];
	logic [7:0] msk [7] = '{8'h3f, 8'h0f, 8'h00, 8'h92, 8'h7f, 8'h00, 8'h00};
	int lst [7] = '{0, 1, 2, 4, 7, 9, 10};
	int failures = 0, comparisons = 0, seed = 23544;
	crg_top #(.AW(AW), .WD_BASE_SHIFT(2), .PI_BASE_SHIFT(1)) dut (.*);
	crg_partner u_far (.*);
	initial forever #10 aclk = ~aclk;
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] x);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, x};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		// Loop test sees pre-update values, so it must follow the first edge
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) s_axi_bready <= 0;
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	task automatic rc(int i);
		@(posedge aclk);
		s_axi_araddr <= 8'(i * 4);
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) s_axi_rready <= 0;
			if (s_axi_rvalid) d = s_axi_rdata;
			if (s_axi_rvalid) r = s_axi_rresp;
		end while (s_axi_arvalid || s_axi_rready);
		chk($sformatf("reg%0d", i), {24'h00_0000, mdl[i]}, d);
		chk("rresp", (i > 11) ? 2 : 0, {30'h0, r});
	endtask
	initial begin
		#300_000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		for (int n = 0; n < 300 && sys_reset_n !== 1; n++) @(posedge aclk);
		for (int i = 0; i < 13; i++) mdl[i] = (i == 6) ? 8'hf1 : (i == 3) ? 8'h40 : 8'h00;
		for (int i = 0; i < 13; i++) rc(i);
		for (int j = 0; j < 14; j++) begin
			v = 8'($random(seed));
			wr(8'(lst[j % 7] * 4), v);
			mdl[lst[j % 7]] = v & msk[j % 7];
			rc(lst[j % 7]);
		end
		wr(8'h1c, 0);
		wr(8'h10, 0);
		wr(8'h0c, 8'hff);
		mdl[3] = 0;
		rc(3);
		wr(8'h1c, 8'h01);
		repeat (20) @(posedge aclk);
		wr(8'h1c, 0);
		mdl[3] = 8'h80;
		rc(3);
		wr(8'h0c, 8'h80);
		wr(8'h10, 8'h10);
		ana[1] <= 1;
		for (int n = 0; n < 20 && irq !== 1; n++) @(posedge aclk);
		chk("irq", 1, irq);
		wr(8'h10, 0);
		repeat (2) @(posedge aclk);
		chk("irq", 0, irq);
		wr(8'h0c, 8'h10);
		ana[1] <= 0;
		repeat (8) @(posedge aclk);
		mdl[3] = 8'h10;
		rc(3);
		wr(8'h0c, 8'h10);
		for (int m = 0; m < 3; m++) begin
			wr(8'h14, (m == 0) ? 8'h20 : (m == 1) ? 8'h00 : 8'h40);
			wait_req <= (m == 0);
			stop_req <= (m != 0);
			@(posedge aclk);
			wait_req <= 0;
			stop_req <= 0;
			repeat (2) @(posedge aclk);
			chk("sys_clk_en", 0, clk_ctl.sys_clk_en);
			chk("osc_enable", m != 1, clk_ctl.osc_enable);
			wake_req <= 1;
			@(posedge aclk);
			wake_req <= 0;
			repeat (2) @(posedge aclk);
			chk("sys_clk_en", 1, clk_ctl.sys_clk_en);
		end
		ana[3] <= 1;
		for (int n = 0; n < 20 && clk_ctl.self_clock_status !== 1; n++) @(posedge aclk);
		chk("quality_check", 1, clk_ctl.quality_check);
		ana[3] <= 0;
		repeat (10) @(posedge aclk);
		chk("self_clock", 1, clk_ctl.self_clock_status);
		ana[2] <= 1;
		for (int n = 0; n < 20 && clk_ctl.self_clock_status !== 0; n++) @(posedge aclk);
		ana[2] <= 0;
		mdl[3] = 8'h02;
		rc(3);
		wr(8'h18, 8'h80);
		ana[3] <= 1;
		for (int n = 0; n < 20 && sys_reset_n !== 0; n++) @(posedge aclk);
		chk("pin_oe", 1, reset_pin_oe);
		ana[3] <= 0;
		for (int n = 0; n < 300 && sys_reset_n !== 1; n++) @(posedge aclk);
		mdl[3] = 0;
		rc(3);
		rc(6);
		pin_low <= 1;
		for (int n = 0; n < 10 && sys_reset_n !== 0; n++) @(posedge aclk);
		chk("sys_reset_n", 0, sys_reset_n);
		pin_low <= 0;
		for (int n = 0; n < 300 && sys_reset_n !== 1; n++) @(posedge aclk);
		chk("sys_reset_n", 1, sys_reset_n);
		// Arm key long before the last quarter of the period must reset
		wr(8'h20, 8'h81);
		wr(8'h2c, 8'h55);
		repeat (3) @(posedge aclk);
		chk("wd_window", 0, sys_reset_n);
		end_of_test();
	end
endmodule
